/* flash_guard_map.svh */
// Offsets, field positions, geometry and timing counts for the Flash modify guard.
// Assumes a 20 MHz system clock and a 32-bit Avalon-MM register port with byte addresses.
`ifndef FLASH_GUARD_MAP_SVH
`define FLASH_GUARD_MAP_SVH

// Register byte offsets
`define FG_PSC_OFS 5'h00
`define FG_RSR_OFS 5'h04
`define FG_MON_OFS 5'h08
`define FG_FSR_OFS 5'h0c
`define FG_IST_OFS 5'h10
`define FG_IMK_OFS 5'h14

// Program store control fields
`define FG_PSC_WE_BIT 0
`define FG_PSC_EE_BIT 1

// Reset source register fields
`define FG_RSR_MONRST_BIT 0
`define FG_RSR_POR_BIT 1
`define FG_RSR_FERR_BIT 6

// Supply monitor control and Flash scale fields
`define FG_MON_EN_BIT 0
`define FG_FSR_BYPASS_BIT 6

// Interrupt status bits
`define FG_INT_ERR_BIT 0
`define FG_INT_DONE_BIT 1
`define FG_INT_ROW_BIT 2
`define FG_INT_W 3

// Flash geometry
`define FG_ROW_LSB 7
`define FG_ADDR_W 16
`define FG_IRQ_W 4
`define FG_ERASE_DATA 8'h00

// Timing: clock period, modify operation time and wake bound
`define FG_CLK_NS 50
`define FG_OP_TIME_NS 400
`define FG_OP_CYCLES ((`FG_OP_TIME_NS + `FG_CLK_NS - 1) / `FG_CLK_NS)
`define FG_WAKE_MAX_CYCLES 3

`endif

/* flash_guard_pkg.sv */
// Types shared by the Flash modify guard and its read power helper.
// Assumes the map header for every number.
package flash_guard_pkg;

    // Kind of Flash modify operation in progress
    typedef enum logic [1:0] {
        OP_IDLE,
        OP_WRITE,
        OP_ERASE
    } flash_op_e;

    typedef logic [3:0] op_count_t;

endpackage

/* flash_read_power.sv */
// Flash read power helper: sense-amp one-shot with bypass and row-change detect.
// Assumes access and address come from logic on the system clock.
`include "flash_guard_map.svh"

module flash_read_power (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic reset_n_i,
    // Control
    input wire logic bypass_i,
    // Read access
    input wire logic access_i,
    input wire logic [`FG_ADDR_W-1:0] addr_i,
    // Power controls
    output logic sense_amp_en_o,
    output logic row_switch_o
);
    import flash_guard_pkg::*;

    logic sense_q;
    logic row_sw_q;
    logic [`FG_ADDR_W-1:`FG_ROW_LSB] last_row_q;

    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
            sense_q <= 1'b0;
        end else begin
            sense_q <= bypass_i | access_i;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
            last_row_q <= '0;
            row_sw_q <= 1'b0;
        end else begin
            row_sw_q <= access_i && (addr_i[`FG_ADDR_W-1:`FG_ROW_LSB] != last_row_q);
            if (access_i) begin
                last_row_q <= addr_i[`FG_ADDR_W-1:`FG_ROW_LSB];
            end
        end
    end

    assign sense_amp_en_o = sense_q;
    assign row_switch_o = row_sw_q;

    chk_oneshot_pulse: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
        !bypass_i && !access_i |=> !sense_amp_en_o)
        else $error("sense amps on with no access and no bypass");

    chk_bypass_holds_on: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
        bypass_i [*2] |-> sense_amp_en_o)
        else $error("sense amps off while bypassed");

    chk_row_change_flag: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
        access_i ##1 access_i && addr_i[`FG_ADDR_W-1:`FG_ROW_LSB] != $past(addr_i[`FG_ADDR_W-1:`FG_ROW_LSB])
        |=> row_switch_o)
        else $error("row change not flagged");

endmodule // flash_read_power

/* flash_modify_guard.sv */
// Flash modify guard: supply monitor gate, modify sequencing, interrupt hold,
// idle wake and read power control, with an Avalon-MM register port.
// Assumes all inputs come from logic on clk_sys_i; reset_n_i is the power-on reset.
//
// How it works
// - Modify needs monitor and its reset enabled
// - Monitor and reset source on after reset
// - Interrupts held during modify, then by priority
// - Write enable at control bit zero gates modify
// - Erase needs write and erase enable
// - Idle wake within three clock cycles
// - One-shot sense pulse per access cycle
// - One-shot on at reset, bypass bit disables
// - Rows of 128 bytes, crossings flagged
// - Erase clears whole page, data ignored
// - Error reset leaves error flag set
`include "flash_guard_map.svh"

module flash_modify_guard (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic reset_n_i,
    // Avalon-MM register port
    input wire logic [4:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    // CPU Flash modify requests
    input wire logic flash_wr_req_i,
    input wire logic [`FG_ADDR_W-1:0] flash_addr_i,
    input wire logic [7:0] flash_data_i,
    output logic flash_busy_o,
    output logic flash_prog_o,
    output logic flash_erase_o,
    output logic [`FG_ADDR_W-1:0] flash_prog_addr_o,
    output logic [7:0] flash_prog_data_o,
    output flash_guard_pkg::flash_op_e op_kind_o,
    output logic flash_error_reset_o,
    // Flash reads
    input wire logic flash_read_i,
    input wire logic [`FG_ADDR_W-1:0] flash_read_addr_i,
    output logic sense_amp_en_o,
    output logic row_switch_o,
    // Peripheral interrupts towards the CPU
    input wire logic [`FG_IRQ_W-1:0] periph_irq_i,
    input wire logic cpu_int_enable_i,
    input wire logic [`FG_IRQ_W-1:0] irq_ack_i,
    output logic [`FG_IRQ_W-1:0] irq_grant_o,
    // Idle mode
    input wire logic idle_enter_i,
    output logic cpu_run_o,
    // Block interrupt
    output logic irq_o
);
    import flash_guard_pkg::*;

    logic [1:0] psc_q;
    logic mon_rst_en_q;
    logic mon_en_q;
    logic por_flag_q;
    logic ferr_flag_q;
    logic bypass_q;
    logic [`FG_INT_W-1:0] int_st_q;
    logic [`FG_INT_W-1:0] int_mk_q;
    logic ack_q;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    flash_op_e op_q;
    op_count_t cnt_q;
    logic prog_q;
    logic erase_q;
    logic err_q;
    logic done_q;
    logic [`FG_ADDR_W-1:0] addr_q;
    logic [7:0] data_q;
    logic [`FG_IRQ_W-1:0] pend_q;
    logic [`FG_IRQ_W-1:0] grant_d;
    logic idle_q;
    logic row_sw;
    logic bus_req;
    logic wr_acc;
    logic req_taken;
    logic guard_ok;

    // Bus handshake: one wait cycle, then the access completes
    assign bus_req = avs_read_i | avs_write_i;
    assign avs_waitrequest_o = bus_req & ~ack_q;
    assign wr_acc = avs_write_i & ack_q;

    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= bus_req & ~ack_q;
        end
    end

    // Read data mux, unmapped reads as zero
    always_comb begin
        rdata_d = 32'h0000_0000;
        unique case (avs_address_i)
            `FG_PSC_OFS: rdata_d[1:0] = psc_q;
            `FG_RSR_OFS: begin
                rdata_d[`FG_RSR_MONRST_BIT] = mon_rst_en_q;
                rdata_d[`FG_RSR_POR_BIT] = por_flag_q;
                rdata_d[`FG_RSR_FERR_BIT] = ferr_flag_q;
            end
            `FG_MON_OFS: rdata_d[`FG_MON_EN_BIT] = mon_en_q;
            `FG_FSR_OFS: rdata_d[`FG_FSR_BYPASS_BIT] = bypass_q;
            `FG_IST_OFS: rdata_d[`FG_INT_W-1:0] = int_st_q;
            `FG_IMK_OFS: rdata_d[`FG_INT_W-1:0] = int_mk_q;
            default: rdata_d = 32'h0000_0000;
        endcase
    end

    // Read data captured in the wait cycle
    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
            rdata_q <= 32'h0000_0000;
        end else if (avs_read_i && !ack_q) begin
            rdata_q <= rdata_d;
        end
    end
    assign avs_readdata_o = rdata_q;

    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
            psc_q <= 2'h0;
        end else if (wr_acc && avs_address_i == `FG_PSC_OFS) begin
            psc_q <= avs_writedata_i[1:0];
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
            mon_rst_en_q <= 1'b1;
            mon_en_q <= 1'b1;
        end else begin
            if (wr_acc && avs_address_i == `FG_RSR_OFS) begin
                mon_rst_en_q <= avs_writedata_i[`FG_RSR_MONRST_BIT];
            end
            if (wr_acc && avs_address_i == `FG_MON_OFS) begin
                mon_en_q <= avs_writedata_i[`FG_MON_EN_BIT];
            end
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
            por_flag_q <= 1'b1;
            ferr_flag_q <= 1'b0;
        end else if (req_taken && !guard_ok) begin
            por_flag_q <= 1'b0;
            ferr_flag_q <= 1'b1;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
            bypass_q <= 1'b0;
        end else if (wr_acc && avs_address_i == `FG_FSR_OFS) begin
            bypass_q <= avs_writedata_i[`FG_FSR_BYPASS_BIT];
        end
    end

    assign guard_ok = mon_en_q & mon_rst_en_q;
    // only counts with write enable set
    assign req_taken = flash_wr_req_i & psc_q[`FG_PSC_WE_BIT] & (op_q == OP_IDLE);

    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
            op_q <= OP_IDLE;
            cnt_q <= '0;
            prog_q <= 1'b0;
            erase_q <= 1'b0;
            err_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            prog_q <= 1'b0;
            erase_q <= 1'b0;
            err_q <= 1'b0;
            done_q <= 1'b0;
            unique case (op_q)
                OP_IDLE: begin
                    if (req_taken && !guard_ok) begin
                        err_q <= 1'b1;
                    end else if (req_taken) begin
                        cnt_q <= op_count_t'(`FG_OP_CYCLES - 1);
                        if (psc_q[`FG_PSC_EE_BIT]) begin
                            op_q <= OP_ERASE;
                            erase_q <= 1'b1;
                        end else begin
                            op_q <= OP_WRITE;
                            prog_q <= 1'b1;
                        end
                    end
                end
                OP_WRITE, OP_ERASE: begin
                    if (cnt_q == '0) begin
                        op_q <= OP_IDLE;
                        done_q <= 1'b1;
                    end else begin
                        cnt_q <= cnt_q - op_count_t'(1);
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
            addr_q <= '0;
            data_q <= 8'h00;
        end else if (req_taken && guard_ok) begin
            addr_q <= flash_addr_i;
            data_q <= psc_q[`FG_PSC_EE_BIT] ? `FG_ERASE_DATA : flash_data_i;
        end
    end

    assign flash_busy_o = (op_q != OP_IDLE);
    assign flash_prog_o = prog_q;
    assign flash_erase_o = erase_q;
    assign flash_prog_addr_o = addr_q;
    assign flash_prog_data_o = data_q;
    assign op_kind_o = op_q;
    assign flash_error_reset_o = err_q;

    genvar gi;
    generate
        for (gi = 0; gi < `FG_IRQ_W; gi++) begin : g_pend
            always_ff @(posedge clk_sys_i) begin
                if (!reset_n_i) begin
                    pend_q[gi] <= 1'b0;
                end else begin
                    pend_q[gi] <= periph_irq_i[gi] | (pend_q[gi] & ~irq_ack_i[gi]);
                end
            end
        end
    endgenerate

    // lowest index wins once modify done
    always_comb begin
        grant_d = '0;
        if (!flash_busy_o && cpu_int_enable_i) begin
            grant_d = pend_q & (~pend_q + {{(`FG_IRQ_W-1){1'b0}}, 1'b1});
        end
    end
    assign irq_grant_o = grant_d;

    // idle until any interrupt line fires
    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
            idle_q <= 1'b0;
        end else if (|periph_irq_i) begin
            idle_q <= 1'b0;
        end else if (idle_enter_i) begin
            idle_q <= 1'b1;
        end
    end
    assign cpu_run_o = ~idle_q;

    flash_read_power u_read_power (
        .clk_sys_i(clk_sys_i),
        .reset_n_i(reset_n_i),
        .bypass_i(bypass_q),
        .access_i(flash_read_i),
        .addr_i(flash_read_addr_i),
        .sense_amp_en_o(sense_amp_en_o),
        .row_switch_o(row_sw)
    );
    assign row_switch_o = row_sw;

    // Sticky status, set wins over write-one clear
    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
            int_st_q <= '0;
            int_mk_q <= '0;
        end else begin
            int_st_q <= (int_st_q & ~((wr_acc && avs_address_i == `FG_IST_OFS) ?
                avs_writedata_i[`FG_INT_W-1:0] : '0)) | {row_sw, done_q, err_q};
            if (wr_acc && avs_address_i == `FG_IMK_OFS) begin
                int_mk_q <= avs_writedata_i[`FG_INT_W-1:0];
            end
        end
    end
    assign irq_o = |(int_st_q & int_mk_q);

    chk_guard_blocks_modify: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
        req_taken && !(mon_en_q && mon_rst_en_q) |=> flash_error_reset_o && !flash_prog_o && !flash_erase_o)
        else $error("modify not blocked with monitor off");

    chk_guard_allows_modify: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
        flash_wr_req_i && psc_q[0] && !flash_busy_o && mon_en_q && mon_rst_en_q
        |=> (flash_prog_o || flash_erase_o) && flash_busy_o)
        else $error("permitted modify not started");

    chk_monitor_after_por: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
        $rose(reset_n_i) |-> mon_en_q && mon_rst_en_q && por_flag_q)
        else $error("monitor not enabled after reset");

    chk_irq_held_busy: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
        flash_busy_o || !cpu_int_enable_i |-> irq_grant_o == '0)
        else $error("interrupt granted during modify");

    chk_erase_needs_both: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
        flash_erase_o |-> $past(psc_q) == 2'h3)
        else $error("erase without both enables");

    chk_wake_bound: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
        !cpu_run_o && |periph_irq_i |-> ##[1:3] cpu_run_o)
        else $error("wake from idle too slow");

    chk_erase_data_ignored: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
        flash_erase_o |-> flash_prog_data_o == `FG_ERASE_DATA && flash_prog_addr_o == $past(flash_addr_i))
        else $error("erase carried data or wrong page");

    chk_error_flag_set: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
        flash_error_reset_o |-> ferr_flag_q && !por_flag_q ##1 ferr_flag_q)
        else $error("error flag not set by error reset");

endmodule // flash_modify_guard

/* cpu_core_model.sv */
// CPU core stand-in: issues Flash write instructions and acknowledges granted interrupts.
// Assumes the guard samples every input on the rising edge of the same system clock.
`include "flash_guard_map.svh"

module cpu_core_model (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic reset_n_i,
    // Interrupt handshake
    input wire logic [`FG_IRQ_W-1:0] irq_grant_i,
    output logic [`FG_IRQ_W-1:0] irq_ack_o,
    // Flash write instruction
    output logic wr_req_o,
    output logic [`FG_ADDR_W-1:0] wr_addr_o,
    output logic [7:0] wr_data_o
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        wr_req_o = 1'b0;
        wr_addr_o = '0;
        wr_data_o = 8'h00;
    end

    // modify issued on the one system clock
    // One-cycle write pulse; lines show the inverse once released
    task automatic issue(input logic [`FG_ADDR_W-1:0] a, input logic [7:0] d);
        @(posedge clk_sys_i);
        wr_req_o <= 1'b1;
        wr_addr_o <= a;
        wr_data_o <= d;
        @(posedge clk_sys_i);
        wr_req_o <= 1'b0;
        wr_addr_o <= ~a;
        wr_data_o <= ~d;
    endtask

    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
            irq_ack_o <= '0;
        end else if (irq_ack_o != '0) begin
            irq_ack_o <= '0; // One pulse per grant
        end else begin
            irq_ack_o <= irq_grant_i;
        end
    end
endmodule // cpu_core_model

/* tb_top.sv */
// Bench for the Flash modify guard: bus master, CPU partner and a reference model.
// Assumes the guard, its package and the partner model are compiled first.
`include "flash_guard_map.svh"

module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    import flash_guard_pkg::*;

    logic clk_sys = 1'b0, reset_n = 1'b0;
    logic [4:0] avs_address = '0;
    logic avs_read = 1'b0, avs_write = 1'b0, avs_waitrequest;
    logic [31:0] avs_writedata = '0, avs_readdata, rdata;
    logic wr_req, busy, prog, erase, err_rst, sense_en, row_sw, cpu_run, irq;
    logic [15:0] wr_addr, prog_addr, a;
    logic [15:0] rd_addr = '0;
    logic [7:0] wr_data, prog_data, d, gp;
    logic rd_en = 1'b0, int_en = 1'b0, idle_enter = 1'b0;
    logic [3:0] irq_ev = '0, irq_ack, irq_grant;
    flash_op_e op_kind, gk;
    int num_errors = 0, num_checks = 0, seed = 97735, n, ok, xp, xe, xr, ferr = 0, stat = 0, lrow;
    int got_q[$], ea[42], es[42];
    int ctl_t[6] = '{0, 1, 3, 2, 1, 1}, mon_t[6] = '{1, 1, 1, 1, 0, 1};
    int rsr_t[6] = '{3, 3, 3, 3, 3, 2}, msk_t[6] = '{7, 7, 2, 7, 7, 6};
    int ofs_t[6] = '{0, 4, 8, 12, 16, 24}, rst_t[6] = '{0, 3, 1, 0, 0, 0};
    logic [2:0] gf;

    initial begin
        forever #25 clk_sys = ~clk_sys;
    end

    flash_modify_guard u_dut (.clk_sys_i(clk_sys), .reset_n_i(reset_n), .avs_address_i(avs_address),
        .avs_read_i(avs_read), .avs_write_i(avs_write), .avs_writedata_i(avs_writedata),
        .avs_readdata_o(avs_readdata), .avs_waitrequest_o(avs_waitrequest), .flash_wr_req_i(wr_req),
        .flash_addr_i(wr_addr), .flash_data_i(wr_data), .flash_busy_o(busy), .flash_prog_o(prog),
        .flash_erase_o(erase), .flash_prog_addr_o(prog_addr), .flash_prog_data_o(prog_data),
        .op_kind_o(op_kind), .flash_error_reset_o(err_rst), .flash_read_i(rd_en),
        .flash_read_addr_i(rd_addr), .sense_amp_en_o(sense_en), .row_switch_o(row_sw),
        .periph_irq_i(irq_ev), .cpu_int_enable_i(int_en), .irq_ack_i(irq_ack),
        .irq_grant_o(irq_grant), .idle_enter_i(idle_enter), .cpu_run_o(cpu_run), .irq_o(irq));

    cpu_core_model u_cpu (.clk_sys_i(clk_sys), .reset_n_i(reset_n), .irq_grant_i(irq_grant),
        .irq_ack_o(irq_ack), .wr_req_o(wr_req), .wr_addr_o(wr_addr), .wr_data_o(wr_data));

    // Record each acknowledged line in order
    always @(posedge clk_sys) begin
        if (irq_ack != 4'h0) got_q.push_back(int'(irq_ack));
    end

    task automatic complete_run();
        if (num_errors == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask

    // One Avalon transfer, held until waitrequest is sampled low
    task automatic bus(input logic w, input logic [4:0] ad, input logic [31:0] wd);
        int k = 0;
        @(posedge clk_sys);
        avs_address <= ad;
        avs_writedata <= wd;
        avs_read <= ~w;
        avs_write <= w;
        do begin
            @(posedge clk_sys);
            k++;
        end while (avs_waitrequest !== 1'b0 && k < 20);
        rdata = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        if (k >= 20) begin
            num_errors++;
            complete_run();
        end
    endtask

    task automatic wr(input logic [4:0] ad, input int v);
        bus(1'b1, ad, 32'(v));
    endtask

    task automatic rd_chk(input string nm, input logic [4:0] ad, input int v);
        bus(1'b0, ad, 32'h0);
        chk(nm, 32'(v), rdata);
    endtask

    initial begin
        repeat (12) @(posedge clk_sys);
        reset_n <= 1'b1;
        wr(5'h18, 32'hffffffff);
        // Reset values and the unmapped word
        for (int i = 0; i < 6; i++) rd_chk("reset value", 5'(ofs_t[i]), rst_t[i]);
        // Modify cases: none, write, erase, erase enable alone, monitor off, monitor reset off
        for (int c = 0; c < 6; c++) begin
            wr(`FG_MON_OFS, mon_t[c]);
            wr(`FG_RSR_OFS, rsr_t[c]);
            wr(`FG_IMK_OFS, msk_t[c]);
            wr(`FG_PSC_OFS, ctl_t[c]);
            ok = ctl_t[c] % 2 && mon_t[c] % 2 && rsr_t[c] % 2;
            xp = ok && ctl_t[c] < 2;
            xe = ok && ctl_t[c] >= 2;
            xr = ctl_t[c] % 2 && !ok;
            ferr = ferr | xr;
            stat = stat | xr | (xp || xe) * 2;
            a = 16'($random(seed));
            d = 8'($random(seed));
            int_en <= 1'b0;
            u_cpu.issue(a, d);
            @(posedge clk_sys);
            gf = {prog, erase, err_rst};
            gp = prog_data;
            gk = op_kind;
            chk("start pulses", {xp[0], xe[0], xr[0]}, gf);
            if (xp) chk("write addr data", {a, d}, {prog_addr, gp});
            if (xp || xe) chk("op kind", 32'(xp ? OP_WRITE : OP_ERASE), 32'(gk));
            if (xe) chk("erase data", `FG_ERASE_DATA, gp);
            if (xe) chk("erase page addr", 32'(a), 32'(prog_addr));
            irq_ev <= 4'h6;
            n = 0;
            while (busy === 1'b1 && n < 40) begin
                if (n == 4) int_en <= 1'b1;
                chk("grant while busy", 32'h0, irq_grant);
                @(posedge clk_sys);
                irq_ev <= 4'h0;
                n++;
            end
            @(posedge clk_sys);
            irq_ev <= 4'h0;
            chk("busy cycles", (xp || xe) ? `FG_OP_CYCLES : 0, n);
            int_en <= 1'b1;
            repeat (8) @(posedge clk_sys);
            int_en <= 1'b0;
            chk("grant count", 32'h2, got_q.size());
            if (got_q.size() == 2) chk("grant order", 32'h24, got_q[0] * 16 + got_q[1]);
            got_q.delete();
            // Power-on flag reads zero once an error reset has been requested
            rd_chk("reset sources", `FG_RSR_OFS, ferr * 64 + (ferr ? 0 : 2) + rsr_t[c] % 2);
            rd_chk("status", `FG_IST_OFS, stat);
            chk("interrupt out", 32'((stat & msk_t[c]) != 0), irq);
            wr(`FG_IST_OFS, 7);
            stat = 0;
        end
        // Idle wake
        @(posedge clk_sys);
        idle_enter <= 1'b1;
        @(posedge clk_sys);
        idle_enter <= 1'b0;
        @(posedge clk_sys);
        chk("idle run", 32'h0, cpu_run);
        irq_ev <= 4'h8;
        n = 0;
        do begin
            @(posedge clk_sys);
            irq_ev <= 4'h0;
            n++;
        end while (cpu_run !== 1'b1 && n < 10);
        chk("wake within bound", 32'h1, n <= `FG_WAKE_MAX_CYCLES);
        // Read accesses around the 128-byte row boundary at 0x1000
        lrow = 0;
        for (int i = 0; i < 42; i++) begin
            @(posedge clk_sys);
            if (i >= 2) chk("sense enable", ea[i - 2], sense_en);
            if (i >= 3) chk("row switch", es[i - 2], row_sw);
            a = (i == 0) ? 16'h0 : 16'h0f80 + 16'($random(seed) & 255);
            ea[i] = (i == 0) || (i < 40 && ($random(seed) & 1));
            es[i] = ea[i] && (a >> `FG_ROW_LSB) != lrow;
            if (ea[i]) lrow = a >> `FG_ROW_LSB;
            rd_en <= ea[i][0];
            rd_addr <= a;
        end
        wr(`FG_IMK_OFS, 4);
        bus(1'b0, `FG_IST_OFS, 32'h0);
        chk("row status", 32'h4, rdata & 32'h4);
        chk("row interrupt", 32'h1, irq);
        wr(`FG_IST_OFS, 7);
        rd_chk("status cleared", `FG_IST_OFS, 0);
        chk("interrupt cleared", 32'h0, irq);
        // Bypass at this clock rate, then back to the one-shot
        wr(`FG_FSR_OFS, 32'h40);
        rd_chk("bypass set", `FG_FSR_OFS, 32'h40);
        repeat (2) @(posedge clk_sys);
        repeat (3) begin
            @(posedge clk_sys);
            chk("bypassed sense", 32'h1, sense_en);
        end
        wr(`FG_FSR_OFS, 0);
        repeat (3) @(posedge clk_sys);
        chk("one-shot back", 32'h0, sense_en);
        complete_run();
    end
endmodule // tb_top
